// ===== core/apd_audio_core.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`include "apd_regs.svh"

module apd_audio_core
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Packet strobes from the receiver core
    input apd_pkg::apd_pkt_t pktIn,
    input wire logic pktDetRst,
    // Pins from outside the clock domain
    input wire logic lineSyncPin,
    input wire logic bitClkPin,
    input wire logic spdif0In,
    input wire logic wordClkIn,
    input wire logic [3:0] serialIn,
    input wire logic [5:0] dsdIn,
    // Audio output ports
    output logic [5:0] audioPort,
    // Formatter configuration and status
    output logic [1:0] serialFormat,
    output logic [4:0] wordLength,
    output apd_pkg::apd_mode_t activeMode,
    // Interrupt
    output logic irq
);
    import apd_pkg::*;

    // ==========================================
    // Pin synchronisers
    localparam int SYNC_W = 14;
    logic [SYNC_W-1:0] pinRaw;
    logic [SYNC_W-1:0] syncAQ;
    logic [SYNC_W-1:0] syncBQ;
    logic lineDlyQ, bitDlyQ;
    logic lineEdge, bitFall;
    logic lineS, bitS, spdifS, wclkS;
    logic [3:0] serialS;
    logic [5:0] dsdS;

    assign pinRaw = {dsdIn, serialIn, wordClkIn, spdif0In, bitClkPin, lineSyncPin};

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            syncAQ <= '0;
            syncBQ <= '0;
            lineDlyQ <= 1'b0;
            bitDlyQ <= 1'b0;
        end
        else
        begin
            syncAQ <= pinRaw;
            syncBQ <= syncAQ;
            lineDlyQ <= lineS;
            bitDlyQ <= bitS;
        end
    end

    assign {dsdS, serialS, wclkS, spdifS, bitS, lineS} = syncBQ;

    // Leading edge of line sync taken as its rising edge
    assign lineEdge = lineS & ~lineDlyQ;
    assign bitFall = ~bitS & bitDlyQ;

    // ==========================================
    // Packet detection flags
    logic [3:0] pktVec;
    logic [3:0] flags;

    assign pktVec = pktIn;

    genvar i;
    generate
        for (i = 0; i < 4; i++)
        begin : g_det
            logic others;
            assign others = |(pktVec & ~(4'h1 << i));
            apd_flag_timer u_timer
            (
                .sys_clk(sys_clk),
                .sys_rst(sys_rst),
                .setPulse(pktVec[i]),
                .killPulse(others),
                .lineEdge(lineEdge),
                .detRst(pktDetRst),
                .flag(flags[i])
            );
        end
    endgenerate

    // ==========================================
    // Processed mode and change flag
    apd_mode_t modeD, modeQ;
    logic chgQ, statusRead;
    logic [31:0] prdataQ;

    always_comb
    begin
        if (flags[3])
            modeD = APD_HBR;
        else if (flags[2])
            modeD = APD_DST;
        else if (flags[1])
            modeD = APD_DSD;
        else if (flags[0])
            modeD = APD_SAMPLE;
        else
            modeD = APD_NONE;
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            modeQ <= APD_NONE;
        else
            modeQ <= modeD;
    end

    // Set beats the read-clear; only a change the read returned is cleared
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            chgQ <= 1'b0;
        else if (modeD != modeQ)
            chgQ <= 1'b1;
        else if (statusRead && prdataQ[`APD_CHG_BIT])
            chgQ <= 1'b0;
    end

    // ==========================================
    // APB register file
    logic [4:0] wlenQ;
    logic [1:0] fmtQ;
    apd_map_cfg_t mapQ;
    logic copyQ, mask1Q, mask2Q;
    logic pslverrQ, preadyQ;
    logic [7:0] idx;
    logic aligned, hit, setup, wrAcc;
    logic [31:0] rdD;

    assign idx = paddr[9:2];
    assign aligned = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    assign setup = psel & ~penable;
    assign wrAcc = psel & penable & pwrite & hit;
    assign statusRead = psel & penable & ~pwrite & hit & (idx == `APD_IDX_STATUS);

    always_comb
    begin
        rdD = 32'h0;
        hit = aligned;
        unique case (idx)
            `APD_IDX_FORMAT:
            begin
                rdD[`APD_WLEN_LSB +: 5] = wlenQ;
                rdD[`APD_FMT_LSB +: 2] = fmtQ;
            end
            `APD_IDX_PKTDET: rdD[3:0] = flags;
            `APD_IDX_MAP:
            begin
                rdD[`APD_ROT_LSB +: 2] = mapQ.rotate;
                rdD[`APD_REV_BIT] = mapQ.reverse;
            end
            `APD_IDX_COPY: rdD[`APD_COPY_BIT] = copyQ;
            `APD_IDX_STATUS: rdD[`APD_CHG_BIT] = chgQ;
            `APD_IDX_MASK1: rdD[`APD_CHG_BIT] = mask1Q;
            `APD_IDX_MASK2: rdD[`APD_CHG_BIT] = mask2Q;
            default: hit = 1'b0;
        endcase
    end

    // Answer is prepared in the setup cycle, so every access is zero-wait
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prdataQ <= 32'h0;
            pslverrQ <= 1'b0;
            preadyQ <= 1'b0;
        end
        else
        begin
            preadyQ <= 1'b1;
            if (setup)
            begin
                prdataQ <= (hit && !pwrite) ? rdD : 32'h0;
                pslverrQ <= ~hit;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wlenQ <= `APD_WLEN_RST;
            fmtQ <= `APD_FMT_RST;
            mapQ <= '{reverse: 1'b0, rotate: `APD_ROT_RST};
            copyQ <= 1'b0;
            mask1Q <= 1'b0;
            mask2Q <= 1'b0;
        end
        else if (wrAcc)
        begin
            unique case (idx)
                `APD_IDX_FORMAT:
                begin
                    wlenQ <= pwdata[`APD_WLEN_LSB +: 5];
                    fmtQ <= pwdata[`APD_FMT_LSB +: 2];
                end
                `APD_IDX_MAP:
                begin
                    // Any pairing of the two fields is legal
                    mapQ.rotate <= pwdata[`APD_ROT_LSB +: 2];
                    mapQ.reverse <= pwdata[`APD_REV_BIT];
                end
                `APD_IDX_COPY: copyQ <= pwdata[`APD_COPY_BIT];
                `APD_IDX_MASK1: mask1Q <= pwdata[`APD_CHG_BIT];
                `APD_IDX_MASK2: mask2Q <= pwdata[`APD_CHG_BIT];
                default:
                begin
                end
            endcase
        end
    end

    // ==========================================
    // Interrupt
    logic irqQ;

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            irqQ <= 1'b0;
        else
            irqQ <= chgQ & (mask1Q | mask2Q);
    end

    // ==========================================
    // Output port mapping
    logic [3:0] mapped;
    logic [5:0] portD, portQ;

    apd_port_map u_map
    (
        .cfg(mapQ),
        .streamIn(serialS),
        .portOut(mapped)
    );

    always_comb
    begin
        if (modeQ == APD_DSD)
            portD = dsdS;
        else
        begin
            portD[0] = spdifS;
            portD[1] = copyQ ? spdifS : mapped[0];
            portD[4:2] = mapped[3:1];
            portD[5] = wclkS;
        end
    end

    // Ports change on the falling bit-clock edge so the sink samples stable data
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            portQ <= 6'h00;
        else if (bitFall)
            portQ <= portD;
    end

    assign audioPort = portQ;
    assign serialFormat = fmtQ;
    assign wordLength = wlenQ;
    assign activeMode = modeQ;
    assign irq = irqQ;
    assign prdata = prdataQ;
    assign pslverr = pslverrQ;
    assign pready = preadyQ;

    // ==========================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    logic [3:0] dstEdgesQ;

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            dstEdgesQ <= 4'hF;
        else if (pktVec[2])
            dstEdgesQ <= 4'h0;
        else if (lineEdge && dstEdgesQ != 4'hF)
            dstEdgesQ <= dstEdgesQ + 4'h1;
    end

    sequence seqPortUpdate;
        bitFall && copyQ && modeQ != APD_DSD;
    endsequence

    sequence seqPlainMap;
        bitFall && !copyQ && modeQ != APD_DSD && mapQ == 3'b000;
    endsequence

    chk_dsd_set: assert property (pktVec[1] && !pktDetRst |=> flags[1])
        else $error("DSD flag not set after DSD packet");
    chk_dsd_kill: assert property (|(pktVec & 4'hD) && !pktVec[1] |=> !flags[1])
        else $error("DSD flag survived another packet type");
    chk_dst_kill: assert property (|(pktVec & 4'hB) && !pktVec[2] |=> !flags[2])
        else $error("DST flag survived another packet type");
    chk_hbr_kill: assert property (|(pktVec & 4'h7) && !pktVec[3] |=> !flags[3])
        else $error("HBR flag survived another packet type");
    chk_det_reset: assert property (pktDetRst |=> flags == 4'h0)
        else $error("Flags not cleared by packet-detect reset");
    chk_dst_expire: assert property (dstEdgesQ == 4'hB |-> !flags[2])
        else $error("DST flag held past eleventh line sync");
    chk_dst_hold: assert property (dstEdgesQ < 4'hB && !$past(|(pktVec & 4'hB))
        && !$past(pktDetRst) && $past(flags[2]) |-> flags[2])
        else $error("DST flag dropped early");
    chk_irq_mask: assert property (chgQ && (mask1Q || mask2Q) |=> irq)
        else $error("Unmasked change did not interrupt");
    chk_irq_off: assert property (!(mask1Q || mask2Q) |=> !irq)
        else $error("Interrupt raised while both masks off");
    chk_mode_change: assert property (modeD != modeQ |=> chgQ ##1 modeQ == $past(modeD, 2)
        || chgQ)
        else $error("Mode change not flagged");
    chk_copy_port: assert property (seqPortUpdate |=> audioPort[1] == $past(spdifS))
        else $error("Port 1 does not carry port-0 SPDIF");
    chk_plain_map: assert property (seqPlainMap |=> audioPort[4:1] == $past(serialS))
        else $error("Default stream mapping wrong");

endmodule : apd_audio_core

// ===== core/apd_regs.svh
`ifndef APD_REGS_SVH
`define APD_REGS_SVH

// ==========================================
// Register indices (byte address = index * 4)
`define APD_IDX_FORMAT 8'h03
`define APD_IDX_PKTDET 8'h18
`define APD_IDX_MAP 8'h6D
`define APD_IDX_COPY 8'h6E
`define APD_IDX_STATUS 8'h83
`define APD_IDX_MASK1 8'h84
`define APD_IDX_MASK2 8'h85

// ==========================================
// Field positions
`define APD_WLEN_LSB 0
`define APD_FMT_LSB 5
`define APD_ROT_LSB 4
`define APD_REV_BIT 6
`define APD_COPY_BIT 3
`define APD_CHG_BIT 5

// ==========================================
// Reset values
`define APD_WLEN_RST 5'h18
`define APD_FMT_RST 2'h0
`define APD_ROT_RST 2'h0

// ==========================================
// Timing counts
// Line-sync edges counted after a packet; the next edge clears
`define APD_LINE_HOLD 4'hA

`endif

// ===== core/apd_pkg.sv
package apd_pkg;

    // ==========================================
    // Audio packet types
    typedef enum logic [2:0] {APD_NONE, APD_SAMPLE, APD_DSD, APD_DST, APD_HBR} apd_mode_t;

    // Bit order follows the detection register
    typedef struct packed {
        logic hbr;
        logic dst;
        logic dsd;
        logic sample;
    } apd_pkt_t;

    // ==========================================
    // Serial stream mapping controls
    typedef struct packed {
        logic reverse;
        logic [1:0] rotate;
    } apd_map_cfg_t;

endpackage : apd_pkg

// ===== core/apd_flag_timer.sv
`timescale 1ns/10ps
`include "apd_regs.svh"

module apd_flag_timer
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Events
    input wire logic setPulse,
    input wire logic killPulse,
    input wire logic lineEdge,
    input wire logic detRst,
    // Flag
    output logic flag
);

    logic flagQ;
    logic [3:0] cntQ;

    // ==========================================
    // Detection flag with line-sync timeout
    // Own packet beats a competing one in the same cycle
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            flagQ <= 1'b0;
            cntQ <= 4'h0;
        end
        else if (detRst)
        begin
            flagQ <= 1'b0;
            cntQ <= 4'h0;
        end
        else if (setPulse)
        begin
            flagQ <= 1'b1;
            cntQ <= 4'h0;
        end
        else if (killPulse)
        begin
            flagQ <= 1'b0;
            cntQ <= 4'h0;
        end
        else if (flagQ && lineEdge)
        begin
            if (cntQ == `APD_LINE_HOLD)
            begin
                flagQ <= 1'b0;
                cntQ <= 4'h0;
            end
            else
            begin
                cntQ <= cntQ + 4'h1;
            end
        end
    end

    assign flag = flagQ;

endmodule : apd_flag_timer

// ===== core/apd_port_map.sv
`timescale 1ns/10ps

module apd_port_map
(
    // Controls
    input apd_pkg::apd_map_cfg_t cfg,
    // Streams in, ports 1 to 4 out
    input wire logic [3:0] streamIn,
    output logic [3:0] portOut
);
    import apd_pkg::*;

    logic [3:0] rotated;

    // ==========================================
    // Rotate, then optionally reverse
    genvar p;
    generate
        for (p = 0; p < 4; p++)
        begin : g_map
            logic [1:0] src;
            assign src = 2'(p) - cfg.rotate;
            assign rotated[p] = streamIn[src];
            assign portOut[p] = cfg.reverse ? rotated[3 - p] : rotated[p];
        end
    endgenerate

endmodule : apd_port_map

// ===== tb/apd_audio_src.sv
`timescale 1ns/10ps

module apd_audio_src
(
    // Control from the bench
    input wire logic run,
    input wire logic [3:0] reqSerial,
    input wire logic reqSpdif,
    input wire logic reqWord,
    input wire logic [5:0] reqDsd,
    // Pins toward the block
    output logic bitClkPin,
    output logic [3:0] serialIn,
    output logic spdif0In,
    output logic wordClkIn,
    output logic [5:0] dsdIn,
    // Ports back from the block
    input wire logic [5:0] audioPort,
    output logic [5:0] captured
);
    // ==========================================
    // Bit clock, still and low outside a run
    initial
    begin
        bitClkPin = 1'b0;
        #3.1;
        forever
        begin
            #62.5;
            bitClkPin = run ? ~bitClkPin : 1'b0;
        end
    end

    // ==========================================
    // Data moves on the rising edge so it is steady at the fall
    initial
    begin
        serialIn = 4'h0;
        spdif0In = 1'b0;
        wordClkIn = 1'b0;
        dsdIn = 6'h00;
        captured = 6'h00;
    end

    always @(posedge bitClkPin)
    begin
        serialIn <= reqSerial;
        spdif0In <= reqSpdif;
        wordClkIn <= reqWord;
        dsdIn <= reqDsd;
        captured <= audioPort;
    end
endmodule : apd_audio_src

// ===== tb/testbench.sv
`timescale 1ns/10ps
`include "apd_regs.svh"

module testbench;
    import apd_pkg::*;
    // ==========================================
    // Signals
    logic sysClk = 1'b0, sysRst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, pktDetRst = 1'b0, lineSyncPin = 1'b0, bitClkPin, spdif0In, wordClkIn;
    apd_pkt_t pktIn = '0;
    logic [3:0] serialIn, reqSerial = 4'h0;
    logic [5:0] dsdIn, audioPort, captured, reqDsd = 6'h00;
    logic [1:0] serialFormat;
    logic [4:0] wordLength;
    apd_mode_t activeMode;
    logic irq, run = 1'b0, reqSpdif = 1'b0, reqWord = 1'b0;
    int failCount = 0, testsRun = 0;
    logic [31:0] rd;
    logic err;

    always #2 sysClk = ~sysClk;

    apd_audio_core u_dut (.sys_clk(sysClk), .sys_rst(sysRst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pktIn(pktIn), .pktDetRst(pktDetRst), .lineSyncPin(lineSyncPin),
        .bitClkPin(bitClkPin), .spdif0In(spdif0In), .wordClkIn(wordClkIn), .serialIn(serialIn),
        .dsdIn(dsdIn), .audioPort(audioPort), .serialFormat(serialFormat),
        .wordLength(wordLength), .activeMode(activeMode), .irq(irq));

    apd_audio_src u_src (.run(run), .reqSerial(reqSerial), .reqSpdif(reqSpdif),
        .reqWord(reqWord), .reqDsd(reqDsd), .bitClkPin(bitClkPin), .serialIn(serialIn),
        .spdif0In(spdif0In), .wordClkIn(wordClkIn), .dsdIn(dsdIn), .audioPort(audioPort),
        .captured(captured));

    // ==========================================
    // Shared tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp)
        begin
            failCount++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge sysClk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge sysClk);
        penable <= 1'b1;
        do
        begin
            @(posedge sysClk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic pulse(input apd_pkt_t v);
        @(posedge sysClk);
        pktIn <= v;
        @(posedge sysClk);
        pktIn <= '0;
        repeat (5) @(posedge sysClk);
    endtask : pulse

    task automatic lineEdges(input int n);
        repeat (n)
        begin
            @(posedge sysClk);
            lineSyncPin <= 1'b1;
            repeat (4) @(posedge sysClk);
            lineSyncPin <= 1'b0;
            repeat (4) @(posedge sysClk);
        end
    endtask : lineEdges

    task automatic endTest(input string name);
        $display("test %s done", name);
    endtask : endTest

    task automatic finishTest();
        $display("comparisons %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finishTest

    function automatic logic [5:0] expPorts(input logic [1:0] rot, input logic rev,
        input logic cp, input logic [3:0] s, input logic sp, input logic wc);
        logic [5:0] e;
        int r;
        e[0] = sp;
        e[5] = wc;
        for (int k = 1; k < 5; k++)
        begin
            r = rev ? 5 - k : k;
            e[k] = s[(r - 1 - int'(rot) + 8) % 4];
        end
        if (cp)
            e[1] = sp;
        return e;
    endfunction : expPorts

    // ==========================================
    // Watchdog sized well past the expected run
    initial
    begin
        #100000;
        failCount++;
        finishTest();
    end

    // ==========================================
    // Tests
    initial
    begin
        static logic [7:0] idx [7] = '{8'h03, 8'h18, 8'h6D, 8'h6E, 8'h83, 8'h84, 8'h85};
        static logic [3:0] bits [4] = '{4'h2, 4'h4, 4'h8, 4'h1};
        repeat (2) @(posedge sysClk);
        sysRst <= 1'b0;
        foreach (idx[i])
        begin
            apb(1'b0, idx[i], 32'h0);
            check("reset value", rd, (i == 0) ? 32'h18 : 32'h0);
        end
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
        apb(1'b1, 8'h18, 32'hF);
        apb(1'b0, 8'h18, 32'h0);
        check("read only flags", rd, 32'h0);
        for (int f = 0; f < 4; f++)
        begin
            apb(1'b1, 8'h03, (f << 5) | (f * 9));
            @(posedge sysClk);
            check("format", {30'h0, serialFormat}, f);
            check("word length", {27'h0, wordLength}, f * 9);
        end
        endTest("registers");

        // Each type evicts the previous one
        foreach (bits[i])
        begin
            pulse(bits[i]);
            apb(1'b0, 8'h18, 32'h0);
            check("single flag", rd, bits[i]);
        end
        check("mode sample", activeMode, APD_SAMPLE);
        endTest("eviction");

        // Ten edges keep a flag, the eleventh clears it
        foreach (bits[i])
        begin
            pulse(bits[i]);
            lineEdges(10);
            apb(1'b0, 8'h18, 32'h0);
            check("flag held", rd, bits[i]);
            lineEdges(1);
            apb(1'b0, 8'h18, 32'h0);
            check("flag expired", rd, 32'h0);
        end
        pulse(4'h8);
        @(posedge sysClk);
        pktDetRst <= 1'b1;
        @(posedge sysClk);
        pktDetRst <= 1'b0;
        repeat (3) @(posedge sysClk);
        apb(1'b0, 8'h18, 32'h0);
        check("detect reset", rd, 32'h0);
        endTest("timeout");

        // Change flag and its two masks
        apb(1'b0, 8'h83, 32'h0);
        pulse(4'h2);
        check("masked irq", {31'h0, irq}, 32'h0);
        apb(1'b0, 8'h83, 32'h0);
        check("change flag", rd, 32'h20);
        for (int m = 0; m < 2; m++)
        begin
            apb(1'b1, 8'(8'h84 + m), 32'h20);
            pulse(m ? 4'h1 : 4'h4);
            check("irq raised", {31'h0, irq}, 32'h1);
            apb(1'b0, 8'h83, 32'h0);
            repeat (3) @(posedge sysClk);
            check("irq cleared", {31'h0, irq}, 32'h0);
            apb(1'b1, 8'(8'h84 + m), 32'h0);
        end
        endTest("interrupt");

        // Port mapping over every rotate, reverse and copy setting
        run = 1'b1;
        for (int c = 0; c < 16; c++)
        begin
            apb(1'b1, 8'h6D, ((c & 7) << 4));
            apb(1'b1, 8'h6E, (c >> 3) << 3);
            for (int j = 0; j < 4; j++)
            begin
                reqSerial = 4'h1 << j;
                reqSpdif = j[0];
                reqWord = ~j[0];
                #500;
                check("port map", captured, expPorts(c[1:0], c[2], c[3], 4'h1 << j, j[0],
                    ~j[0]));
            end
        end
        reqDsd = 6'h2D;
        pulse(4'h2);
        #500;
        check("dsd ports", captured, 6'h2D);
        run = 1'b0;
        endTest("mapping");
        finishTest();
    end
endmodule : testbench
